// [hw/dsir_pkg.sv]
// Constants and carrier types for the DSI initialization and status responder
package dsir_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_CFG    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESP   = 8'h0c;

    // Command codes and addresses
    localparam logic [3:0] CODE_INIT   = 4'h0;
    localparam logic [3:0] CODE_STATUS = 4'h1;
    localparam logic [3:0] ADDR_GLOBAL = 4'h0;

    // Response lengths in bits
    localparam logic [4:0] LEN_LONG      = 5'h10;
    localparam logic [4:0] LEN_SHORT_MIN = 5'h08;
    localparam logic [4:0] LEN_SHORT_MAX = 5'h0f;

    // One bit per bank selection code, set where the code is accepted
    localparam logic [3:0] VALID_BANK_MASK = 4'h7;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // Received command as delivered by the link layer
    typedef struct packed {
        logic [4:0] resp_len;
        logic       crc_ok;
        logic       enhanced;
        logic       long_fmt;
        logic [3:0] code;
        logic [3:0] addr;
        logic [7:0] data;
    } dsir_cmd_t;

    // Software configuration of the sensor side
    typedef struct packed {
        logic       enh_enable;
        logic       self_test_active;
        logic [1:0] attribute_bits;
        logic       programmed;
        logic [3:0] stored_addr;
    } dsir_cfg_t;

    // Response frame handed back to the link layer
    typedef struct packed {
        logic        valid;
        logic [4:0]  len;
        logic [15:0] data;
    } dsir_resp_t;

    localparam int        CMD_W   = 24;
    localparam int        CFG_W   = 9;
    localparam int        RESP_W  = 22;
    localparam dsir_cmd_t CMD_RST = 24'h00_0000;
    localparam dsir_cfg_t CFG_RST = 9'h000;
    localparam dsir_resp_t RESP_RST = 22'h00_0000;

endpackage

// [hw/dsir_responder.sv]
// Initialization and status command responder with AHB-Lite registers
module dsir_responder
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Sensor side pins
    input  wire logic        internal_fault,
    input  wire logic        reservoir_low,
    input  wire logic        downstream_bus_short,
    // Control outputs
    output logic             bus_switch_close,
    output logic             otp_program_enable,
    output logic      [1:0]  bank_select,
    output logic             resp_strobe
);

    typedef enum logic [3:0]
    {
        S_IDLE    = 4'b0001,
        S_CHECK   = 4'b0010,
        S_BUSTEST = 4'b0100,
        S_REPLY   = 4'b1000
    } dsir_state_t;

    // Keeps the low len bits, zero padding above
    function automatic logic [15:0] fit_len(input logic [15:0] d,
                                            input logic [4:0]  len);
        logic [15:0] mask;
        mask = 16'h0000;
        for (int i = 0; i < 16; i++)
        begin
            mask[i] = (5'(i) < len);
        end
        fit_len = d & mask;
    endfunction

    // Format acceptance used by the status command only
    function automatic logic fmt_ok(input dsir_pkg::dsir_cmd_t c,
                                    input logic             enh_en);
        logic len_ok;
        len_ok = c.long_fmt ||
                 ((c.resp_len >= dsir_pkg::LEN_SHORT_MIN) &&
                  (c.resp_len <= dsir_pkg::LEN_SHORT_MAX));
        fmt_ok = len_ok && (!c.enhanced || enh_en);
    endfunction

    // Pin synchronisers
    logic [2:0]              sync1_ff;
    logic [2:0]              sync2_ff;
    // Bus slave
    logic                    wr_pend_ff;
    logic [7:0]              wr_addr_ff;
    logic [31:0]             hrdata_ff;
    logic                    hreadyout_ff;
    logic                    hresp_ff;
    // Command handling
    dsir_pkg::dsir_cmd_t     cmd_ff;
    dsir_pkg::dsir_cfg_t     cfg_ff;
    dsir_pkg::dsir_resp_t    resp_ff;
    dsir_pkg::dsir_resp_t    nxt_resp;
    dsir_state_t             state_ff;
    dsir_state_t             nxt_state;
    logic                    start_ff;
    logic                    init_done_ff;
    logic                    nxt_init_done;
    logic [3:0]              node_addr_ff;
    logic [3:0]              nxt_node_addr;
    logic [1:0]              bank_ff;
    logic [1:0]              nxt_bank;
    logic                    nv_ff;
    logic                    nxt_nv;
    logic                    bs_req_ff;
    logic                    nxt_bs_req;
    logic                    switch_ff;
    logic                    nxt_switch;
    logic                    bf_ff;
    logic                    nxt_bf;
    logic                    strobe_ff;

    // Synchronised pin levels
    wire logic fault_s = sync2_ff[0];
    wire logic ulow_s  = sync2_ff[1];
    wire logic short_s = sync2_ff[2];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end
        else
        begin
            sync1_ff <= {downstream_bus_short, reservoir_low, internal_fault};
            sync2_ff <= sync1_ff;
        end
    end

    // Address phase decode
    wire logic       addr_phase = hsel && hready &&
                                  (htrans == dsir_pkg::HTRANS_NONSEQ);
    wire logic [7:0] a_ofs      = haddr[7:0];
    wire logic       rd_req     = addr_phase && !hwrite;
    wire logic       wr_req     = addr_phase && hwrite;
    wire logic       busy       = !state_ff[0] || start_ff;

    // Write side effects in the data phase
    wire logic wr_cmd  = wr_pend_ff && (wr_addr_ff == dsir_pkg::OFS_CMD);
    wire logic wr_cfg  = wr_pend_ff && (wr_addr_ff == dsir_pkg::OFS_CFG);
    wire logic take_cmd = wr_cmd && !busy;
    // Reading the response word hands it over and frees the slot
    wire logic rd_resp  = rd_req && (a_ofs == dsir_pkg::OFS_RESP);

    wire logic [31:0] status_word = {17'h0_0000, fault_s, ulow_s, short_s,
                                     busy, init_done_ff, resp_ff.valid,
                                     bf_ff, switch_ff, nv_ff, bank_ff,
                                     node_addr_ff};

    wire logic [31:0] rd_mux =
        (a_ofs == dsir_pkg::OFS_CMD)    ? {8'h00, cmd_ff}         :
        (a_ofs == dsir_pkg::OFS_CFG)    ? {23'h00_0000, cfg_ff}   :
        (a_ofs == dsir_pkg::OFS_STATUS) ? status_word             :
        (a_ofs == dsir_pkg::OFS_RESP)   ? {10'h000, resp_ff}      :
                                          32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff   <= 1'b0;
            wr_addr_ff   <= 8'h00;
            hrdata_ff    <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= dsir_pkg::HRESP_OKAY;
        end
        else
        begin
            wr_pend_ff   <= wr_req;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= dsir_pkg::HRESP_OKAY;
            if (addr_phase)
            begin
                wr_addr_ff <= a_ofs;
            end
            if (rd_req)
            begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    // Configuration register, steers the status contents
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_ff <= dsir_pkg::CFG_RST;
        end
        else if (wr_cfg)
        begin
            cfg_ff <= dsir_pkg::dsir_cfg_t'(hwdata[dsir_pkg::CFG_W-1:0]);
        end
    end

    // A command written while one is in flight is dropped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd_ff   <= dsir_pkg::CMD_RST;
            start_ff <= 1'b0;
        end
        else
        begin
            start_ff <= take_cmd;
            if (take_cmd)
            begin
                cmd_ff <= dsir_pkg::dsir_cmd_t'(hwdata[dsir_pkg::CMD_W-1:0]);
            end
        end
    end

    // Initialization acceptance
    wire logic [3:0] pa_field  = cmd_ff.data[3:0];
    wire logic [1:0] bank_fld  = cmd_ff.data[5:4];
    wire logic       bs_fld    = cmd_ff.data[6];
    wire logic       nv_fld    = cmd_ff.data[7];
    wire logic       is_init   = (cmd_ff.code == dsir_pkg::CODE_INIT);
    wire logic       is_status = (cmd_ff.code == dsir_pkg::CODE_STATUS);

    wire logic addr_match_pre = cfg_ff.programmed &&
                                (pa_field == cfg_ff.stored_addr) &&
                                (cmd_ff.addr == cfg_ff.stored_addr);
    wire logic addr_match_new = !cfg_ff.programmed &&
                                (cmd_ff.addr == dsir_pkg::ADDR_GLOBAL);
    wire logic pa_nonzero     = (pa_field != dsir_pkg::ADDR_GLOBAL);
    wire logic bank_valid     = dsir_pkg::VALID_BANK_MASK[bank_fld];

    // Standard long only, and only once
    wire logic init_ok = cmd_ff.crc_ok && is_init && !init_done_ff &&
                         cmd_ff.long_fmt && !cmd_ff.enhanced &&
                         (addr_match_pre || addr_match_new) &&
                         pa_nonzero && bank_valid;

    // Data byte of a status request is deliberately not examined
    wire logic status_ok = cmd_ff.crc_ok && is_status && init_done_ff &&
                           (node_addr_ff != dsir_pkg::ADDR_GLOBAL) &&
                           (cmd_ff.addr == node_addr_ff) &&
                           fmt_ok(cmd_ff, cfg_ff.enh_enable);

    // Status low byte shared by short and long forms
    wire logic [7:0] status_low = {nv_ff,
                                   ulow_s,
                                   cfg_ff.self_test_active,
                                   switch_ff,
                                   cfg_ff.attribute_bits,
                                   fault_s,
                                   1'b0};

    wire logic [15:0] status_short = {8'h00, status_low};
    wire logic [15:0] status_long  = {node_addr_ff, 4'h0, status_low};

    wire logic [4:0] status_len = cmd_ff.long_fmt ? dsir_pkg::LEN_LONG
                                                  : cmd_ff.resp_len;

    // Link layer appends the 4-bit CRC to this word
    wire logic [15:0] init_word = {node_addr_ff, 3'h0, bf_ff, nv_ff,
                                   bs_req_ff, bank_ff,
                                   node_addr_ff};

    // Bus test outcome decides the switch
    wire logic test_fault   = short_s;
    wire logic switch_after = !test_fault && bs_req_ff;

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_init_done = init_done_ff;
        nxt_node_addr = node_addr_ff;
        nxt_bank      = bank_ff;
        nxt_nv        = nv_ff;
        nxt_bs_req    = bs_req_ff;
        nxt_switch    = switch_ff;
        nxt_bf        = bf_ff;
        nxt_resp      = resp_ff;
        if (rd_resp)
        begin
            nxt_resp.valid = 1'b0;
        end
        case (state_ff)
            S_IDLE:
            begin
                if (start_ff)
                begin
                    nxt_state = S_CHECK;
                end
            end
            S_CHECK:
            begin
                if (init_ok)
                begin
                    nxt_node_addr = pa_field;
                    nxt_bank      = bank_fld;
                    nxt_nv        = nv_fld;
                    nxt_bs_req    = bs_fld;
                    nxt_init_done = 1'b1;
                    nxt_state     = S_BUSTEST;
                end
                else if (status_ok)
                begin
                    nxt_state = S_REPLY;
                end
                else
                begin
                    // Refused or corrupted: nothing changes
                    nxt_state = S_IDLE;
                end
            end
            S_BUSTEST:
            begin
                nxt_bf     = test_fault;
                nxt_switch = switch_after;
                nxt_state  = S_REPLY;
            end
            S_REPLY:
            begin
                // A new response outranks a read that clears the old one
                nxt_resp.valid = 1'b1;
                if (is_init)
                begin
                    nxt_resp.len  = dsir_pkg::LEN_LONG;
                    nxt_resp.data = init_word;
                end
                else
                begin
                    nxt_resp.len  = status_len;
                    nxt_resp.data = fit_len(cmd_ff.long_fmt ? status_long
                                                            : status_short,
                                            status_len);
                end
                nxt_state = S_IDLE;
            end
            default:
            begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff     <= S_IDLE;
            init_done_ff <= 1'b0;
            node_addr_ff <= 4'h0;
            bank_ff      <= 2'h0;
            nv_ff        <= 1'b0;
            bs_req_ff    <= 1'b0;
            switch_ff    <= 1'b0;
            bf_ff        <= 1'b0;
            resp_ff      <= dsir_pkg::RESP_RST;
            strobe_ff    <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            init_done_ff <= nxt_init_done;
            node_addr_ff <= nxt_node_addr;
            bank_ff      <= nxt_bank;
            nv_ff        <= nxt_nv;
            bs_req_ff    <= nxt_bs_req;
            switch_ff    <= nxt_switch;
            bf_ff        <= nxt_bf;
            resp_ff      <= nxt_resp;
            strobe_ff    <= state_ff[3];
        end
    end

    // Outputs straight from flip-flops
    assign hrdata             = hrdata_ff;
    assign hreadyout          = hreadyout_ff;
    assign hresp              = hresp_ff;
    assign bus_switch_close   = switch_ff;
    assign otp_program_enable = nv_ff;
    assign bank_select        = bank_ff;
    assign resp_strobe        = strobe_ff;

    // Narrow transfers are treated as whole words
    wire logic unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:24]};

endmodule

// [tb/dsir_responder_monitor.sv]
// Port checks for the initialization and status responder
module dsir_responder_monitor
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus request
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // Control outputs
    input wire logic        bus_switch_close,
    input wire logic        otp_program_enable,
    input wire logic [1:0]  bank_select,
    input wire logic        resp_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire cmd_wr = hsel && hready && hwrite
        && htrans == dsir_pkg::HTRANS_NONSEQ
        && haddr[7:0] == dsir_pkg::OFS_CMD;
    logic                pend_ff;
    logic                init_ff;
    dsir_pkg::dsir_cmd_t cmd_ff;
    wire                 is_init = cmd_ff.code == dsir_pkg::CODE_INIT;
    // Holds the latest command; valid because writes never overlap busy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_ff <= 1'b0;
            init_ff <= 1'b0;
            cmd_ff  <= '0;
        end
        else
        begin
            pend_ff <= cmd_wr;
            if (pend_ff)
                cmd_ff <= dsir_pkg::dsir_cmd_t'(hwdata[23:0]);
            if (resp_strobe && is_init)
                init_ff <= 1'b1;
        end
    end
    sequence s_quiet; !resp_strobe [*2]; endsequence
    property p_pulse; resp_strobe |=> s_quiet; endproperty
    property p_crc; resp_strobe |-> cmd_ff.crc_ok; endproperty
    property p_global; resp_strobe && !is_init
        |-> cmd_ff.addr != dsir_pkg::ADDR_GLOBAL; endproperty
    property p_zero; resp_strobe && is_init
        |-> cmd_ff.data[3:0] != 4'h0; endproperty
    property p_bank; $changed(bank_select)
        |-> bank_select == cmd_ff.data[5:4] && bank_select != 2'h3;
    endproperty
    property p_otp; $changed(otp_program_enable)
        |-> otp_program_enable == cmd_ff.data[7]; endproperty
    property p_switch; $rose(bus_switch_close)
        |-> is_init && cmd_ff.data[6]; endproperty
    property p_once; init_ff |->
        $stable({bank_select, otp_program_enable, bus_switch_close});
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("response strobe longer than one cycle");
    a_crc: assert property (p_crc)
        else $error("response to a command with bad crc");
    a_global: assert property (p_global)
        else $error("status answered at global address");
    a_zero: assert property (p_zero)
        else $error("init answered for address zero");
    a_bank: assert property (p_bank)
        else $error("bank select not from a valid init");
    a_otp: assert property (p_otp)
        else $error("program enable not from init data");
    a_switch: assert property (p_switch)
        else $error("switch closed without request");
    a_once: assert property (p_once)
        else $error("state changed by a later init");
endmodule
bind dsir_responder dsir_responder_monitor u_mon
(
    .hclk               (hclk),
    .hresetn            (hresetn),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hwdata             (hwdata),
    .hready             (hready),
    .bus_switch_close   (bus_switch_close),
    .otp_program_enable (otp_program_enable),
    .bank_select        (bank_select),
    .resp_strobe        (resp_strobe)
);

// [tb/dsir_master_model.sv]
// Bus master that hands commands and reads to the responder
module dsir_master_model
(
    // Clock
    input  wire logic        hclk,
    // AHB-Lite master side
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        hsel = 1'b0;
        haddr = '0;
        htrans = '0;
        hwrite = 1'b0;
        hsize = dsir_pkg::HSIZE_WORD;
        hwdata = '0;
    end
    // Entered just after a rising edge; any command byte is legal
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= dsir_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the initialization and status responder
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic lng, enh, ecfg, st, crc, flt, low, ok;
        logic [4:0] len;
        logic [3:0] adr;
        logic [7:0] dat;
    } dsir_row_t;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        internal_fault, reservoir_low, downstream_bus_short;
    logic        bus_switch_close, otp_program_enable, resp_strobe;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, bank_select;
    logic [2:0]  hsize;
    logic [7:0]  lo;
    dsir_row_t   r;
    int          bad_count, samples_checked, cycles, strobes;
    // Status polls: long, short, address miss, format, crc
    dsir_row_t   rows [8] = '{
        '{1, 0, 0, 1, 1, 0, 0, 1, 5'h00, 4'h5, 8'hff},
        '{0, 0, 0, 1, 1, 1, 0, 1, 5'h08, 4'h5, 8'h00},
        '{0, 0, 0, 0, 1, 0, 1, 1, 5'h0f, 4'h5, 8'h5a},
        '{1, 0, 0, 1, 1, 1, 1, 1, 5'h00, 4'h5, 8'ha5},
        '{1, 0, 0, 1, 1, 0, 0, 0, 5'h00, 4'h6, 8'h00},
        '{0, 1, 0, 1, 1, 0, 0, 0, 5'h0a, 4'h5, 8'h00},
        '{0, 1, 1, 1, 1, 0, 0, 1, 5'h0a, 4'h5, 8'h00},
        '{1, 0, 0, 1, 0, 0, 0, 0, 5'h00, 4'h5, 8'h00}};
    dsir_master_model u_master (.hclk(hclk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata));
    dsir_responder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .internal_fault(internal_fault), .reservoir_low(reservoir_low),
        .downstream_bus_short(downstream_bus_short),
        .bus_switch_close(bus_switch_close),
        .otp_program_enable(otp_program_enable),
        .bank_select(bank_select), .resp_strobe(resp_strobe));
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Counts strobes; a run still going at 3000 cycles, well past the whole test, ends as a failure
    always @(posedge hclk)
    begin
        cycles++;
        if (resp_strobe === 1'b1)
            strobes++;
        if (cycles == 3000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    function automatic logic [31:0] cw(input logic lng, crc,
        input logic [4:0] len, input logic [3:0] code, adr,
        input logic [7:0] d);
        dsir_pkg::dsir_cmd_t c;
        c = '{len, crc, 1'b0, lng, code, adr, d};
        return {8'h00, c};
    endfunction
    task automatic cmd(input logic [31:0] w, input logic ok,
                       input logic [15:0] ed, input logic [4:0] el);
        int n;
        n = strobes;
        u_master.xfer(1'b1, 32'(dsir_pkg::OFS_CMD), w, rd);
        repeat (14) @(posedge hclk);
        #1;
        `CHK("strobe", ok ? n + 1 : n, strobes)
        u_master.xfer(1'b0, 32'(dsir_pkg::OFS_RESP), '0, rd);
        `CHK("valid", ok, rd[21])
        if (ok)
            `CHK("frame", {el, ed}, rd[20:0])
    endtask
    task automatic cfg(input logic [8:0] v);
        u_master.xfer(1'b1, 32'(dsir_pkg::OFS_CFG), {23'h0, v}, rd);
    endtask
    initial
    begin
        hresetn = 1'b0;
        internal_fault = 1'b0;
        reservoir_low = 1'b0;
        downstream_bus_short = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        `CHK("idle", 6'h10, {hresp, hreadyout, bus_switch_close,
            otp_program_enable, bank_select})
        for (int a = 8; a <= 16; a += 4)
        begin
            u_master.xfer(1'b0, 32'(a), '0, rd);
            `CHK("reset read", 32'h0000_0000, rd)
        end
        $display("test reset done");
        cmd(cw(1, 1, 0, dsir_pkg::CODE_INIT, 0, 8'hd0), 0, 0, 0);
        cmd(cw(1, 1, 0, dsir_pkg::CODE_INIT, 0, 8'h37), 0, 0, 0);
        cmd(cw(1, 0, 0, dsir_pkg::CODE_INIT, 0, 8'hd5), 0, 0, 0);
        cmd(cw(1, 1, 0, dsir_pkg::CODE_INIT, 3, 8'hd5), 0, 0, 0);
        cmd(cw(1, 1, 0, dsir_pkg::CODE_STATUS, 0, 0), 0, 0, 0);
        cmd(cw(1, 1, 0, dsir_pkg::CODE_INIT, 0, 8'hd5), 1, 16'h50d5,
            dsir_pkg::LEN_LONG);
        `CHK("switch", 4'hd, {bus_switch_close, otp_program_enable,
            bank_select})
        u_master.xfer(1'b0, 32'(dsir_pkg::OFS_STATUS), '0, rd);
        `CHK("status reg", 32'h0000_04d5, rd)
        cmd(cw(1, 1, 0, dsir_pkg::CODE_INIT, 5, 8'h25), 0, 0, 0);
        `CHK("held", 4'hd, {bus_switch_close, otp_program_enable,
            bank_select})
        $display("test init done");
        foreach (rows[i])
        begin
            r = rows[i];
            internal_fault <= r.flt;
            reservoir_low <= r.low;
            cfg({r.ecfg, r.st, 2'h2, 1'b0, 4'h0});
            lo = {1'b1, r.low, r.st, 1'b1, 2'h2, r.flt, 1'b0};
            cmd(cw(r.lng, r.crc, r.len, dsir_pkg::CODE_STATUS, r.adr,
                r.dat) | {14'h0, r.enh, 17'h0}, r.ok,
                r.lng ? {8'h50, lo} : {8'h00, lo},
                r.lng ? dsir_pkg::LEN_LONG : r.len);
        end
        $display("test status done");
        hresetn <= 1'b0;
        downstream_bus_short <= 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cfg({4'h0, 1'b1, 4'h9});
        cmd(cw(1, 1, 0, dsir_pkg::CODE_INIT, 0, 8'h69), 0, 0, 0);
        cmd(cw(1, 1, 0, dsir_pkg::CODE_INIT, 9, 8'h69), 1, 16'h9169,
            dsir_pkg::LEN_LONG);
        `CHK("fault switch", 3'h2, {bus_switch_close, bank_select})
        $display("test bus fault done");
        wrap_up();
    end
endmodule
